/* qfr_pkg.sv */
// constants and types shared by the quad read sequencer
package qfr_pkg;
    localparam logic [7:0] OP_QREAD  = 8'heb;
    localparam logic [7:0] OP_WORD   = 8'he7;
    localparam logic [7:0] OP_OCTAL  = 8'he3;
    localparam logic [7:0] OP_WRAP   = 8'h77;
    localparam logic [7:0] OP_PARAM  = 8'hc0;
    localparam logic [3:0] CLK_OPC_SPI    = 4'h8;
    localparam logic [3:0] CLK_OPC_QCM    = 4'h2;
    localparam logic [3:0] CLK_ADDR       = 4'h6;
    localparam logic [3:0] CLK_MODE       = 4'h2;
    localparam logic [3:0] CLK_CFG        = 4'h2;
    localparam logic [3:0] DUM_QREAD_SPI  = 4'h4;
    localparam logic [3:0] DUM_WORD       = 4'h2;
    localparam logic [3:0] DUM_OCTAL      = 4'h0;
    localparam logic [1:0] MODE_CONT      = 2'h2;
    localparam int         MODE_PAIR_LSB  = 4;
    localparam int         WRAP_DIS_POS   = 4;
    localparam int         WRAP_LEN_LSB   = 5;
    localparam int         PARAM_LSB      = 4;
    localparam int         ADDR_W         = 24;
    localparam int         SECT_MAX_LSB   = 6;
    localparam logic [3:0][7:0] WRAP_MASK = {8'h3f, 8'h1f, 8'h0f, 8'h07};
    localparam logic [7:0] UNDERRUN_BYTE  = 8'hff;

    typedef enum logic [3:0] {
        ST_IDLE, ST_OPC, ST_ADDR, ST_MODE, ST_DUMMY,
        ST_DATA, ST_WRAP, ST_PARAM, ST_IGNORE
    } qfr_state_t;

    typedef struct packed {
        logic       wrap_dis;
        logic [1:0] wrap_len;
        logic [1:0] dummy_sel;
    } qfr_cfg_t;

    localparam qfr_cfg_t CFG_RST = '{wrap_dis: 1'b1, wrap_len: 2'h0, dummy_sel: 2'h0};
endpackage

/* qfr_read.sv */
// quad read sequencer: byte fifo and serial-side state machine
`timescale 1ns/1ps

module qfr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
        logic          full;
        logic          empty;
    } qfr_fifo_t;

    qfr_fifo_t        q;
    qfr_fifo_t        d;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic             push;
    logic             pop;

    // refuse shapes that the wrapping pointer arithmetic cannot serve
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_shape_chk
        $error("fifo depth must be a power of two of at least two");
    end

    assign push      = in_valid && !q.full;
    assign pop       = out_ready && !q.empty;
    assign in_ready  = !q.full;
    assign out_valid = !q.empty;
    assign out_data  = mem_q[q.rd];

    always_comb begin
        d = q;
        if (flush) begin
            d.wr  = '0;
            d.rd  = '0;
            d.cnt = '0;
        end else begin
            if (push) begin
                d.wr = q.wr + 1'b1;
            end
            if (pop) begin
                d.rd = q.rd + 1'b1;
            end
            d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
        d.full  = (d.cnt == (AW+1)'(DEPTH));
        d.empty = (d.cnt == '0);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q       <= '0;
            q.empty <= 1'b1;
        end else begin
            q <= d;
        end
    end

    always_ff @(posedge clk) begin
        if (push && !flush) begin
            mem_q[q.wr] <= in_data;
        end
    end
endmodule

module qfr_read
    import qfr_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic              CLK,
    input  wire logic              RST,
    input  wire logic              CS_N,
    input  wire logic              SCK,
    input  wire logic [3:0]        IO_IN,
    output logic [3:0]             IO_OUT,
    output logic [3:0]             IO_OE,
    input  wire logic              QUAD_EN,
    input  wire logic              QPI_REQ,
    input  wire logic              SOFT_RST,
    output logic                   QPI_ACTIVE,
    output logic                   CONT_MODE,
    output logic                   WRAP_DIS,
    output logic                   MEM_REQ,
    output logic [ADDR_W-1:0]      MEM_ADDR,
    input  wire logic              MEM_VALID,
    input  wire logic [7:0]        MEM_DATA,
    output logic                   MEM_READY
);
    typedef struct packed {
        logic [2:0]        sck_s;
        logic [2:0]        cs_s;
        logic [2:0][3:0]   io_s;
        logic              sck_l;
        logic              cs_l;
        qfr_state_t        st;
        logic [3:0]        cnt;
        logic [7:0]        sh;
        logic [7:0]        op;
        logic [ADDR_W-1:0] addr;
        logic              cont;
        logic              qcm;
        qfr_cfg_t          cfg;
        logic [ADDR_W-1:0] faddr;
        logic              wrap_act;
        logic              fetch_on;
        logic              busy;
        logic              drop;
        logic              req;
        logic [7:0]        obyte;
        logic              lo;
        logic              oe;
        logic [3:0]        out;
    } qfr_core_t;

    qfr_core_t   q;
    qfr_core_t   d;
    logic        sck_ok;
    logic        cs_ok;
    logic        rise;
    logic        fall;
    logic        csf;
    logic        csr;
    logic [3:0]  io_now;
    logic [3:0]  opc_lim;
    logic        opc_last;
    logic [7:0]  opc_new;
    logic        mode_last;
    logic [7:0]  mode_new;
    logic        adv;
    logic        f_ready;
    logic        f_valid;
    logic [7:0]  f_data;
    logic        f_pop;
    logic [7:0]  wmask;
    logic [3:0]  qcm_dummy;

    if (FIFO_DEPTH < 2) begin : g_depth_chk
        $error("fifo depth too small to hold a prefetched byte");
    end

    // only the second and third stages are compared; the first feeds the second
    assign sck_ok    = (q.sck_s[1] == q.sck_s[2]);
    assign cs_ok     = (q.cs_s[1] == q.cs_s[2]);
    assign rise      = sck_ok && q.sck_s[2] && !q.sck_l && !q.cs_l;
    assign fall      = sck_ok && !q.sck_s[2] && q.sck_l && !q.cs_l;
    assign csf       = cs_ok && !q.cs_s[2] && q.cs_l;
    assign csr       = cs_ok && q.cs_s[2] && !q.cs_l;
    assign io_now    = q.io_s[2];
    assign opc_lim   = q.qcm ? CLK_OPC_QCM : CLK_OPC_SPI;
    assign opc_last  = (q.cnt + 4'h1 == opc_lim);
    assign opc_new   = q.qcm ? {q.sh[3:0], io_now} : {q.sh[6:0], io_now[0]};
    assign mode_last = (q.cnt + 4'h1 == CLK_MODE);
    assign mode_new  = {q.sh[3:0], io_now};
    assign adv       = MEM_VALID && q.busy && f_ready && !q.drop;
    assign f_pop     = fall && (q.st == ST_DATA) && !q.lo && f_valid;
    assign wmask     = WRAP_MASK[q.cfg.wrap_len];
    // total dummy is two per step of the field plus the two mode clocks
    assign qcm_dummy = {1'b0, q.cfg.dummy_sel, 1'b0};

    qfr_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (CLK),
        .rst       (RST),
        .flush     (csr),
        .in_valid  (MEM_VALID && q.busy && !q.drop),
        .in_ready  (f_ready),
        .in_data   (MEM_DATA),
        .out_valid (f_valid),
        .out_ready (f_pop),
        .out_data  (f_data)
    );

    always_comb begin
        d = q;
        d.req   = 1'b0;
        d.sck_s = {q.sck_s[1:0], SCK};
        d.cs_s  = {q.cs_s[1:0], CS_N};
        d.io_s  = {q.io_s[1:0], IO_IN};
        if (sck_ok) begin
            d.sck_l = q.sck_s[2];
        end
        if (cs_ok) begin
            d.cs_l = q.cs_s[2];
        end

        case (q.st)
            ST_IDLE: begin
                d.qcm = QPI_REQ && QUAD_EN;
                if (csf) begin
                    d.cnt = 4'h0;
                    d.sh  = 8'h00;
                    if (q.cont) begin
                        d.st = ST_ADDR;
                    end else begin
                        d.st = ST_OPC;
                    end
                end
            end
            ST_OPC: begin
                if (rise) begin
                    d.sh  = opc_new;
                    d.cnt = q.cnt + 4'h1;
                    if (opc_last) begin
                        d.cnt = 4'h0;
                        d.op  = opc_new;
                        d.st  = ST_IGNORE;
                        case (opc_new)
                            OP_QREAD: begin
                                if (QUAD_EN) begin
                                    d.st = ST_ADDR;
                                end
                            end
                            OP_WORD: begin
                                if (QUAD_EN && !q.qcm) begin
                                    d.st = ST_ADDR;
                                end
                            end
                            OP_OCTAL: begin
                                if (QUAD_EN && !q.qcm) begin
                                    d.st = ST_ADDR;
                                end
                            end
                            OP_WRAP: begin
                                if (!q.qcm) begin
                                    d.st = ST_ADDR;
                                end
                            end
                            OP_PARAM: begin
                                if (q.qcm) begin
                                    d.st = ST_PARAM;
                                end
                            end
                            default: begin
                                d.st = ST_IGNORE;
                            end
                        endcase
                    end
                end
            end
            ST_ADDR: begin
                if (rise) begin
                    d.addr = {q.addr[ADDR_W-5:0], io_now};
                    d.cnt  = q.cnt + 4'h1;
                    if (q.cnt + 4'h1 == CLK_ADDR) begin
                        d.cnt = 4'h0;
                        d.sh  = 8'h00;
                        if (q.op == OP_WRAP) begin
                            d.st = ST_WRAP;
                        end else begin
                            d.st       = ST_MODE;
                            d.faddr    = {q.addr[ADDR_W-5:0], io_now};
                            d.fetch_on = 1'b1;
                            // wrap only for the two wrap-aware reads in serial mode
                            d.wrap_act = !q.cfg.wrap_dis && !q.qcm &&
                                         (q.op == OP_QREAD ||
                                          q.op == OP_WORD);
                        end
                    end
                end
            end
            ST_MODE: begin
                if (rise) begin
                    d.sh  = mode_new;
                    d.cnt = q.cnt + 4'h1;
                    if (mode_last) begin
                        // lower nibble is never looked at
                        d.cont = (mode_new[MODE_PAIR_LSB +: 2] == MODE_CONT);
                        d.cnt  = DUM_OCTAL;
                        if (q.op == OP_QREAD) begin
                            d.cnt = q.qcm ? qcm_dummy : DUM_QREAD_SPI;
                        end else if (q.op == OP_WORD) begin
                            d.cnt = DUM_WORD;
                        end
                        if (d.cnt == 4'h0) begin
                            d.st = ST_DATA;
                        end else begin
                            d.st = ST_DUMMY;
                        end
                        d.lo = 1'b0;
                    end
                end
            end
            ST_DUMMY: begin
                if (rise) begin
                    d.cnt = q.cnt - 4'h1;
                    if (q.cnt == 4'h1) begin
                        d.st = ST_DATA;
                    end
                end
            end
            ST_DATA: begin
                if (fall) begin
                    d.oe = 1'b1;
                    d.lo = !q.lo;
                    if (!q.lo) begin
                        // an empty fifo here means the clock outran memory
                        d.obyte = f_valid ? f_data : UNDERRUN_BYTE;
                        d.out   = d.obyte[7:4];
                    end else begin
                        d.out = q.obyte[3:0];
                    end
                end
            end
            ST_WRAP: begin
                if (rise) begin
                    d.sh  = mode_new;
                    d.cnt = q.cnt + 4'h1;
                    if (q.cnt + 4'h1 == CLK_CFG) begin
                        d.cfg.wrap_dis = mode_new[WRAP_DIS_POS];
                        d.cfg.wrap_len = mode_new[WRAP_LEN_LSB +: 2];
                        d.st           = ST_IGNORE;
                    end
                end
            end
            ST_PARAM: begin
                if (rise) begin
                    d.sh  = mode_new;
                    d.cnt = q.cnt + 4'h1;
                    if (q.cnt + 4'h1 == CLK_CFG) begin
                        d.cfg.dummy_sel = mode_new[PARAM_LSB +: 2];
                        d.st            = ST_IGNORE;
                    end
                end
            end
            ST_IGNORE: begin
                d.st = ST_IGNORE;
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase

        // prefetch: one request outstanding, fifo back-pressure holds memory
        if (q.fetch_on && !q.busy && !q.drop) begin
            d.req  = 1'b1;
            d.busy = 1'b1;
        end
        if (MEM_VALID && q.busy && f_ready) begin
            d.busy = 1'b0;
            d.drop = 1'b0;
        end
        if (adv) begin
            if (q.wrap_act) begin
                d.faddr[7:0] = (q.faddr[7:0] & ~wmask) |
                               ((q.faddr[7:0] + 8'h01) & wmask);
            end else begin
                d.faddr = q.faddr + 24'h1;
            end
        end

        if (csr) begin
            d.st       = ST_IDLE;
            d.oe       = 1'b0;
            d.fetch_on = 1'b0;
            d.req      = 1'b0;
            d.drop     = q.busy && !(MEM_VALID && f_ready);
            d.busy     = q.busy && !(MEM_VALID && f_ready);
        end
        if (SOFT_RST) begin
            d.cfg  = CFG_RST;
            d.cont = 1'b0;
            d.qcm  = 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            q       <= '0;
            q.st    <= ST_IDLE;
            q.cfg   <= CFG_RST;
            q.cs_s  <= 3'h7;
            q.cs_l  <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign IO_OUT     = q.out;
    assign IO_OE      = {4{q.oe}};
    assign QPI_ACTIVE = q.qcm;
    assign CONT_MODE  = q.cont;
    assign WRAP_DIS   = q.cfg.wrap_dis;
    assign MEM_REQ    = q.req;
    assign MEM_ADDR   = q.faddr;
    assign MEM_READY  = f_ready;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    chk_qe_gate: assert property (
        (q.st == ST_OPC && rise && opc_last && !QUAD_EN && opc_new == OP_QREAD)
        |=> q.st == ST_IGNORE)
        else $error("quad read accepted without quad enable");

    chk_word_gate: assert property (
        (q.st == ST_OPC && rise && opc_last && !QUAD_EN && opc_new == OP_WORD)
        |=> q.st == ST_IGNORE)
        else $error("word read accepted without quad enable");

    chk_cont_skip: assert property (
        (q.st == ST_IDLE && csf && q.cont && !csr && !SOFT_RST)
        |=> q.st == ST_ADDR && q.cnt == 4'h0)
        else $error("continuous read did not skip the opcode");

    chk_cont_exit: assert property (
        (q.st == ST_MODE && rise && mode_last && !csr
         && mode_new[MODE_PAIR_LSB +: 2] != MODE_CONT)
        |=> !q.cont)
        else $error("continuous mode kept with wrong mode pair");

    chk_spi_dummy: assert property (
        (q.st == ST_MODE && rise && mode_last && !csr && q.op == OP_QREAD && !q.qcm)
        |=> q.st == ST_DUMMY && q.cnt == DUM_QREAD_SPI)
        else $error("serial quad read dummy count wrong");

    chk_word_dummy: assert property (
        (q.st == ST_MODE && rise && mode_last && !csr && q.op == OP_WORD)
        |=> q.st == ST_DUMMY && q.cnt == DUM_WORD)
        else $error("word read dummy count wrong");

    chk_octal_direct: assert property (
        (q.st == ST_MODE && rise && mode_last && !csr && q.op == OP_OCTAL)
        |=> q.st == ST_DATA)
        else $error("octal read inserted dummy clocks");

    chk_qcm_shared: assert property (
        (q.st == ST_MODE && rise && mode_last && !csr && q.op == OP_QREAD
         && q.qcm && q.cfg.dummy_sel == CFG_RST.dummy_sel)
        |=> q.st == ST_DATA)
        else $error("default quad mode read did not follow mode bits");

    chk_soft_defaults: assert property (
        SOFT_RST |=> q.cfg.dummy_sel == CFG_RST.dummy_sel && q.cfg.wrap_dis)
        else $error("reset instruction left settings changed");

    chk_wrap_bound: assert property (
        (adv && q.wrap_act && !SOFT_RST)
        |=> q.faddr[ADDR_W-1:SECT_MAX_LSB] == $past(q.faddr[ADDR_W-1:SECT_MAX_LSB]))
        else $error("wrapped read left its section");

    chk_linear_inc: assert property (
        (adv && !q.wrap_act) |=> q.faddr == $past(q.faddr) + 24'h1)
        else $error("linear read did not step by one");

    chk_qcm_needs_qe: assert property (
        (q.st == ST_IDLE && !QUAD_EN) |=> !q.qcm)
        else $error("quad command mode entered without quad enable");
endmodule

/* qfr_host.sv */
// host side model: drives select, serial clock and data lines
`timescale 1ns/1ps
module qfr_host (
    input  wire logic       clk,
    input  wire logic [3:0] io_out,
    output logic            cs_n,
    output logic            sck,
    output logic [3:0]      io
);
    logic       q = 1'b0;
    logic [3:0] s;
    logic [7:0] rx;
    event       got;
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        io   = 4'h0;
    end
    // 4 clk low, 4 clk high; sampled just before the fall, when the nibble is settled
    task automatic tick(input logic [3:0] v);
        io = v;
        repeat (4) @(negedge clk);
        sck = 1'b1;
        repeat (4) @(negedge clk);
        s   = io_out;
        sck = 1'b0;
    endtask
    task automatic op(input logic [7:0] c);
        if (q) begin
            tick(c[7:4]);
            tick(c[3:0]);
        end else begin
            for (int i = 7; i >= 0; i--) tick({3'h7, c[i]});
        end
    endtask
    task automatic adr(input logic [23:0] a);
        for (int i = 5; i >= 0; i--) tick(a[i*4+:4]);
    endtask
    // released lines toggle each clock so a stale level never looks valid
    task automatic rd(input int d, input int n);
        for (int i = 0; i < d; i++) tick(~io);
        for (int i = 0; i < n; i++) begin
            tick(~io);
            rx[7:4] = s;
            tick(~io);
            rx[3:0] = s;
            ->got;
        end
    endtask
    task automatic sel();
        cs_n = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    task automatic dsel();
        cs_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask
endmodule

/* tb.sv */
// self-checking bench for the quad read sequencer
`timescale 1ns/1ps
module tb
    import qfr_pkg::*;
;
    logic              CLK = 1'b0, RST = 1'b1, QUAD_EN = 1'b1, QPI_REQ = 1'b0;
    logic              SOFT_RST = 1'b0, MEM_VALID = 1'b0, took = 1'b0, pend = 1'b0;
    logic              CS_N, SCK, QPI_ACTIVE, CONT_MODE, WRAP_DIS, MEM_REQ, MEM_READY;
    logic [7:0]        MEM_DATA = 8'h00;
    logic [3:0]        IO_OUT, IO_OE, IO_IN, h_io;
    logic [ADDR_W-1:0] MEM_ADDR, ma;
    logic [7:0]        q[$];
    logic [7:0]        ops[3] = '{OP_QREAD, OP_WORD, OP_OCTAL};
    int                dm[3] = '{4, 2, 0};
    int                seed = 32'h96f4, dly = 0, bad_count = 0, n_checks = 0;
    assign IO_IN = IO_OE[0] ? IO_OUT : h_io;
    always #10 CLK = ~CLK;
    qfr_read i_qfr_read (.CLK(CLK), .RST(RST), .CS_N(CS_N), .SCK(SCK), .IO_IN(IO_IN),
        .IO_OUT(IO_OUT), .IO_OE(IO_OE), .QUAD_EN(QUAD_EN), .QPI_REQ(QPI_REQ),
        .SOFT_RST(SOFT_RST), .QPI_ACTIVE(QPI_ACTIVE), .CONT_MODE(CONT_MODE),
        .WRAP_DIS(WRAP_DIS), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR),
        .MEM_VALID(MEM_VALID), .MEM_DATA(MEM_DATA), .MEM_READY(MEM_READY));
    qfr_host i_qfr_host (.clk(CLK), .io_out(IO_OUT), .cs_n(CS_N), .sck(SCK), .io(h_io));
    function automatic logic [7:0] mem(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction
    always @(posedge CLK) took <= MEM_VALID && MEM_READY;
    // memory answers after a random delay and holds until taken
    always @(negedge CLK) begin
        if (took) MEM_VALID = 1'b0;
        if (MEM_REQ) begin
            ma   = MEM_ADDR;
            dly  = $random(seed) & 3;
            pend = 1'b1;
        end else if (pend && dly > 0) dly--;
        else if (pend) begin
            MEM_VALID = 1'b1;
            MEM_DATA  = mem(ma);
            pend      = 1'b0;
        end
    end
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    always @(i_qfr_host.got) check("data", i_qfr_host.rx, q.pop_front());
    task automatic xact(input logic [7:0] c, input logic [23:0] a, input logic [7:0] m,
                        input int d, input int n, input logic [23:0] w, input bit sk);
        i_qfr_host.sel();
        if (!sk) i_qfr_host.op(c);
        i_qfr_host.adr(a);
        i_qfr_host.tick(m[7:4]);
        i_qfr_host.tick(m[3:0]);
        i_qfr_host.rd(d, 0);
        if (n > 8) begin
            repeat (100) @(negedge CLK);
            check("full", MEM_READY, 1'b0);
        end
        for (int i = 0; i < n; i++) q.push_back(mem((a & ~w) | (24'(a + i) & w)));
        i_qfr_host.rd(0, n);
        if (n == 0) check("oe", IO_OE, 4'h0);
        i_qfr_host.dsel();
    endtask
    task automatic cfg(input logic [7:0] c, input logic [7:0] v);
        i_qfr_host.sel();
        i_qfr_host.op(c);
        if (!i_qfr_host.q) i_qfr_host.adr(24'h0);
        i_qfr_host.tick(v[7:4]);
        i_qfr_host.tick(v[3:0]);
        i_qfr_host.dsel();
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #1500000;
        bad_count++;
        results();
    end
    initial begin
        logic [23:0] a;
        repeat (3) @(negedge CLK);
        RST = 1'b0;
        repeat (6) @(negedge CLK);
        check("wdis", WRAP_DIS, 1'b1);
        a = 24'($random(seed));
        xact(OP_QREAD, {a[23:8], 8'hfa}, 8'h00, 4, 10, '1, 0);
        for (int i = 0; i < 3; i++) begin
            a = 24'($random(seed)) & 24'hfffff0;
            xact(ops[i], a, 8'ha0, dm[i], 2, '1, 0);
            check("cont", CONT_MODE, 1'b1);
            xact(ops[i], a + 24'h10, 8'h00, dm[i], 2, '1, 1);
            check("cont", CONT_MODE, 1'b0);
        end
        xact(OP_QREAD, a, 8'ha0, 4, 1, '1, 0);
        i_qfr_host.sel();
        repeat (8) i_qfr_host.tick(4'h1);
        i_qfr_host.dsel();
        check("cont", CONT_MODE, 1'b0);
        $display("test serial reads done");
        QUAD_EN = 1'b0;
        for (int i = 0; i < 3; i++) xact(ops[i], a, 8'h00, 6, 0, '1, 0);
        QUAD_EN = 1'b1;
        for (int l = 0; l < 4; l++) begin
            cfg(OP_WRAP, {1'b0, 2'(l), 5'h00});
            check("wdis", WRAP_DIS, 1'b0);
            a = 24'($random(seed)) & 24'hfffffe;
            xact(ops[l & 1], a, 8'h00, dm[l & 1], (8 << l) + 2, 24'((8 << l) - 1), 0);
        end
        $display("test wrap done");
        QPI_REQ = 1'b1;
        repeat (4) @(negedge CLK);
        check("qpi", QPI_ACTIVE, 1'b1);
        i_qfr_host.q = 1'b1;
        a = {a[23:8], 8'h3c};
        xact(OP_QREAD, a, 8'ha0, 0, 8, '1, 0);
        xact(OP_QREAD, a, 8'h00, 0, 2, '1, 1);
        cfg(OP_PARAM, 8'h30);
        xact(OP_QREAD, a, 8'ha0, 6, 3, '1, 0);
        $display("test quad command mode done");
        QPI_REQ = 1'b0;
        i_qfr_host.q = 1'b0;
        SOFT_RST = 1'b1;
        @(negedge CLK);
        SOFT_RST = 1'b0;
        @(negedge CLK);
        check("wdis", WRAP_DIS, 1'b1);
        check("cont", CONT_MODE, 1'b0);
        check("qpi", QPI_ACTIVE, 1'b0);
        $display("test soft reset done");
        results();
    end
endmodule
